// ### logic/dslc_pkg.sv
// constants shared by the status and link control register bank
package dslc_pkg;
  // -------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] RESET_CTL_OFS = 8'h01;
  localparam logic [7:0] HEALTH_OFS = 8'h04;
  localparam logic [7:0] LIMIT_HI_OFS = 8'h05;
  localparam logic [7:0] LIMIT_LO_OFS = 8'h06;
  localparam logic [7:0] TIMEOUT_CTL_OFS = 8'h07;
  localparam logic [7:0] I2C_SETUP_OFS = 8'h08;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int RELOAD_BIT = 2;
  localparam int CKSUM_BIT = 7;
  localparam int INIT_BIT = 6;
  localparam int REFOK_BIT = 4;
  localparam int TMO_OFF_BIT = 0;
  localparam int TMO_LSB = 1;
  localparam int REM_BLOCK_BIT = 7;
  localparam int HOLD_LSB = 4;
  localparam int FILT_LSB = 0;
  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] LIMIT_HI_RST = 8'h01;
  localparam logic [7:0] LIMIT_LO_RST = 8'h00;
  localparam logic [7:0] TIMEOUT_CTL_RST = 8'hFE; // 0x7F timeout, running
  localparam logic [7:0] I2C_SETUP_RST = 8'h1C; // hold 0x1, filter 0xC
  localparam logic [6:0] I2C_DEV_ADDR_RST = 7'h30;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TMO_STEP_MS = 2;
  localparam int TMO_STEP_CYC = CLK_HZ / 1000 * TMO_STEP_MS;
  localparam int HOLD_STEP_NS = 50;
  localparam int FILT_STEP_NS = 5;
  localparam int PORTS = 4;
  // -------------------------------------------------------------------
  // local serial slave states
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    SL_IDLE, SL_DEV, SL_DEV_ACK, SL_REG, SL_REG_ACK,
    SL_WDATA, SL_WACK, SL_RDATA, SL_RACK
  } dslc_slave_type;
endpackage : dslc_pkg

// ### logic/dslc_pin_cond.sv
// two-flop synchroniser and programmable glitch filter for one pin
`timescale 1ns/1ps
module dslc_pin_cond (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic pin,
  input wire logic [3:0] depth,
  output logic clean
);
  import dslc_pkg::*;

  typedef struct packed {
    logic [1:0] sy;
    logic [3:0] cnt;
    logic q;
  } dslc_cond_type;

  dslc_cond_type st_r;
  dslc_cond_type st_nxt;

  // glitch rejection
  // a change passes only after it has stood longer than depth cycles
  always_comb begin
    st_nxt = st_r;
    st_nxt.sy = {st_r.sy[0], pin};
    if (st_r.sy[1] == st_r.q) begin
      st_nxt.cnt = 4'h0;
    end else if (st_r.cnt >= depth) begin
      st_nxt.q = st_r.sy[1];
      st_nxt.cnt = 4'h0;
    end else begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  // idle bus level is high
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{sy: 2'b11, cnt: 4'h0, q: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clean = st_r.q;
endmodule : dslc_pin_cond

// ### logic/dslc_regs.sv
// status, parity limit, channel watchdog and local serial port registers
`timescale 1ns/1ps
module dslc_regs #(
  parameter int TMO_STEP_CYCLES = dslc_pkg::TMO_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  input wire logic ref_clock_detect,
  input wire logic rom_load_done,
  input wire logic rom_cksum_good,
  output logic rom_reload_request,
  input wire logic chan_wr,
  input wire logic chan_rd,
  input wire logic [7:0] chan_addr,
  input wire logic [7:0] chan_wdata,
  output logic [7:0] chan_rdata,
  output logic chan_ack,
  output logic chan_rej,
  input wire logic chan_txn_start,
  input wire logic chan_txn_done,
  output logic chan_txn_abort,
  input wire logic [dslc_pkg::PORTS-1:0] par_err,
  input wire logic [dslc_pkg::PORTS-1:0] par_clr,
  output logic [dslc_pkg::PORTS-1:0] par_fault
);
  import dslc_pkg::*;

  typedef struct packed {
    logic [1:0] ref_sy;
    logic cksum_ok;
    logic init_done;
    logic reload;
    logic [7:0] lim_hi;
    logic [7:0] lim_lo;
    logic [7:0] tmo_ctl;
    logic [7:0] setup;
    logic [PORTS-1:0][15:0] pcnt;
    logic [PORTS-1:0] pfault;
    logic wd_run;
    logic [16:0] wd_pre;
    logic [6:0] wd_steps;
    logic abort;
    logic [15:0] sda_dly;
    logic scl_q;
    logic sda_q;
    dslc_slave_type ist;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic ackd;
    logic sda_oe;
    logic sda_o;
    logic [7:0] rdata;
    logic ack;
    logic rej;
  } dslc_state_type;

  dslc_state_type st_r;
  dslc_state_type st_nxt;
  logic scl_f;
  logic sda_f;
  logic sda_h;
  logic scl_rise;
  logic scl_fall;
  logic [1:0] wen;
  logic [1:0][7:0] wad;
  logic [1:0][7:0] wdt;
  logic [7:0] rd_local;
  logic [15:0] limit;
  logic [16:0] pc;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // least time in ns to whole clock cycles, rounded up
  function automatic logic [3:0] ns_to_cyc(input int ns);
    ns_to_cyc = 4'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction : ns_to_cyc

  // register read decode, shared by local and remote masters
  function automatic logic [7:0] rd_reg(input dslc_state_type s,
                                        input logic [7:0] a);
    rd_reg = 8'h00;
    unique case (a)
      HEALTH_OFS: begin
        rd_reg[CKSUM_BIT] = s.cksum_ok;
        rd_reg[INIT_BIT] = s.init_done;
        rd_reg[REFOK_BIT] = s.ref_sy[1];
      end
      LIMIT_HI_OFS: rd_reg = s.lim_hi;
      LIMIT_LO_OFS: rd_reg = s.lim_lo;
      TIMEOUT_CTL_OFS: rd_reg = s.tmo_ctl;
      I2C_SETUP_OFS: rd_reg = s.setup;
      default: rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  // -------------------------------------------------------------------
  // pin conditioning
  // -------------------------------------------------------------------
  // filter depth
  dslc_pin_cond u_scl_cond (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin(scl_in),
    .depth(ns_to_cyc(int'(st_r.setup[FILT_LSB +: 4]) * FILT_STEP_NS)),
    .clean(scl_f)
  );

  dslc_pin_cond u_sda_cond (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin(sda_in),
    .depth(ns_to_cyc(int'(st_r.setup[FILT_LSB +: 4]) * FILT_STEP_NS)),
    .clean(sda_f)
  );

  // sda hold delay
  // sda is seen late so it cannot move before scl has been sampled
  assign sda_h = st_r.sda_dly[ns_to_cyc(
    int'(st_r.setup[HOLD_LSB +: 3]) * HOLD_STEP_NS)];
  assign scl_rise = scl_f && !st_r.scl_q;
  assign scl_fall = !scl_f && st_r.scl_q;
  assign limit = {st_r.lim_hi, st_r.lim_lo};
  assign rd_local = rd_reg(st_r, st_r.ptr);

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    pc = 17'h0;
    wen = 2'b00;
    wad = '0;
    wdt = '0;
    st_nxt.reload = 1'b0;
    st_nxt.abort = 1'b0;
    st_nxt.ack = 1'b0;
    st_nxt.rej = 1'b0;
    st_nxt.ref_sy = {st_r.ref_sy[0], ref_clock_detect};
    st_nxt.sda_dly = {st_r.sda_dly[14:0], sda_f};
    st_nxt.scl_q = scl_f;
    st_nxt.sda_q = sda_h;
    // local slave: bits in on rising scl, decisions on falling scl
    if (scl_rise && st_r.ist inside {SL_DEV, SL_REG, SL_WDATA}) begin
      st_nxt.sh = {st_r.sh[6:0], sda_h};
      st_nxt.bitc = st_r.bitc + 4'h1;
    end
    if (scl_rise && st_r.ist == SL_RACK) begin
      st_nxt.ackd = !sda_h;
    end
    if (scl_fall) begin
      unique case (st_r.ist)
        SL_DEV: if (st_r.bitc == 4'h8) begin
          if (st_r.sh[7:1] == I2C_DEV_ADDR_RST) begin
            st_nxt.rw = st_r.sh[0];
            st_nxt.sda_oe = 1'b1;
            st_nxt.ist = SL_DEV_ACK;
          end else begin
            st_nxt.ist = SL_IDLE;
          end
        end
        SL_REG: if (st_r.bitc == 4'h8) begin
          st_nxt.ptr = st_r.sh;
          st_nxt.sda_oe = 1'b1;
          st_nxt.ist = SL_REG_ACK;
        end
        SL_WDATA: if (st_r.bitc == 4'h8) begin
          wen[1] = 1'b1;
          wad[1] = st_r.ptr;
          wdt[1] = st_r.sh;
          st_nxt.ptr = st_r.ptr + 8'h01;
          st_nxt.sda_oe = 1'b1;
          st_nxt.ist = SL_WACK;
        end
        SL_DEV_ACK, SL_RACK: begin
          if ((st_r.ist == SL_DEV_ACK && st_r.rw) ||
              (st_r.ist == SL_RACK && st_r.ackd)) begin
            st_nxt.sh = rd_local;
            st_nxt.ptr = st_r.ptr + 8'h01;
            st_nxt.sda_oe = !rd_local[7];
            st_nxt.bitc = 4'h1;
            st_nxt.ist = SL_RDATA;
          end else begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.bitc = 4'h0;
            st_nxt.ist = (st_r.ist == SL_DEV_ACK) ? SL_REG : SL_IDLE;
          end
        end
        SL_REG_ACK, SL_WACK: begin
          st_nxt.sda_oe = 1'b0;
          st_nxt.bitc = 4'h0;
          st_nxt.ist = SL_WDATA;
        end
        SL_RDATA: begin
          st_nxt.sh = {st_r.sh[6:0], 1'b0};
          st_nxt.sda_oe = (st_r.bitc == 4'h8) ? 1'b0 : !st_r.sh[6];
          st_nxt.bitc = st_r.bitc + 4'h1;
          if (st_r.bitc == 4'h8) begin
            st_nxt.ist = SL_RACK;
          end
        end
        SL_IDLE: st_nxt.ist = SL_IDLE;
      endcase
    end
    // start and stop override any slave state
    if (scl_f && st_r.scl_q && st_r.sda_q != sda_h) begin
      st_nxt.sda_oe = 1'b0;
      st_nxt.bitc = 4'h0;
      st_nxt.ist = sda_h ? SL_IDLE : SL_DEV;
    end
    // remote accesses from the control channel
    if (chan_rd) begin
      st_nxt.rdata = rd_reg(st_r, chan_addr);
      st_nxt.ack = 1'b1;
    end
    if (chan_wr && st_r.setup[REM_BLOCK_BIT]) begin
      st_nxt.rej = 1'b1;
    end else if (chan_wr) begin
      wen[0] = 1'b1;
      wad[0] = chan_addr;
      wdt[0] = chan_wdata;
      st_nxt.ack = 1'b1;
    end
    // register writes
    // remote first, so a local write to the same register wins
    for (int k = 0; k < 2; k++) begin
      if (wen[k]) begin
        unique case (wad[k])
          LIMIT_HI_OFS: st_nxt.lim_hi = wdt[k];
          LIMIT_LO_OFS: st_nxt.lim_lo = wdt[k];
          TIMEOUT_CTL_OFS: st_nxt.tmo_ctl = wdt[k];
          I2C_SETUP_OFS: st_nxt.setup = wdt[k];
          RESET_CTL_OFS: st_nxt.reload = st_nxt.reload | wdt[k][RELOAD_BIT];
          default: st_nxt.ptr = st_nxt.ptr;
        endcase
      end
    end
    if (st_nxt.reload) begin
      st_nxt.init_done = 1'b0;
      st_nxt.cksum_ok = 1'b0;
    end
    if (rom_load_done) begin
      st_nxt.init_done = 1'b1;
      st_nxt.cksum_ok = rom_cksum_good;
    end
    // parity counting
    // counters saturate; the fault flag is sticky until cleared
    for (int i = 0; i < PORTS; i++) begin
      pc = {1'b0, par_clr[i] ? 16'h0000 : st_r.pcnt[i]};
      if (par_err[i] && pc[15:0] != 16'hFFFF) begin
        pc = pc + 17'h1;
      end
      st_nxt.pcnt[i] = pc[15:0];
      st_nxt.pfault[i] = (st_r.pfault[i] && !par_clr[i]) ||
                         (pc[15:0] >= limit);
    end
    if (chan_txn_start) begin
      st_nxt.wd_run = 1'b1;
      st_nxt.wd_pre = 17'h0;
      st_nxt.wd_steps = 7'h00;
    end else if (chan_txn_done) begin
      st_nxt.wd_run = 1'b0;
    end else if (st_r.wd_run) begin
      if (st_r.wd_pre == 17'(TMO_STEP_CYCLES - 1)) begin
        st_nxt.wd_pre = 17'h0;
        st_nxt.wd_steps = st_r.wd_steps + 7'h01;
        if (st_r.wd_steps + 7'h01 >= st_r.tmo_ctl[7:TMO_LSB]) begin
          st_nxt.abort = 1'b1;
          st_nxt.wd_run = 1'b0;
        end
      end else begin
        st_nxt.wd_pre = st_r.wd_pre + 17'h1;
      end
    end
    if (st_r.tmo_ctl[TMO_OFF_BIT]) begin
      st_nxt.wd_run = 1'b0;
      st_nxt.abort = 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.lim_hi <= LIMIT_HI_RST;
      st_r.lim_lo <= LIMIT_LO_RST;
      st_r.tmo_ctl <= TIMEOUT_CTL_RST;
      st_r.setup <= I2C_SETUP_RST;
      st_r.sda_dly <= 16'hFFFF;
      st_r.scl_q <= 1'b1;
      st_r.sda_q <= 1'b1;
      st_r.ist <= SL_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sda_o = st_r.sda_o;
  assign sda_oe = st_r.sda_oe;
  assign rom_reload_request = st_r.reload;
  assign chan_rdata = st_r.rdata;
  assign chan_ack = st_r.ack;
  assign chan_rej = st_r.rej;
  assign chan_txn_abort = st_r.abort;
  assign par_fault = st_r.pfault;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_abort_cause;
    chan_txn_abort |-> $past(st_r.wd_run) &&
      ($past(st_r.wd_steps) + 7'h01 >= $past(st_r.tmo_ctl[7:1]));
  endproperty
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort without expired timeout");

  property p_off_no_abort;
    st_r.tmo_ctl[0] |=> !chan_txn_abort && !st_r.wd_run;
  endproperty
  a_off_no_abort: assert property (p_off_no_abort)
    else $error("watchdog active while off");

  sequence s_txn_open;
    chan_txn_start && !st_r.tmo_ctl[0];
  endsequence
  property p_restart;
    s_txn_open |=> st_r.wd_run && st_r.wd_steps == 7'h00 &&
      st_r.wd_pre == 17'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("watchdog not restarted");

  property p_par_flag;
    (st_r.pcnt[0] >= limit) && $stable(limit) |-> par_fault[0];
  endproperty
  a_par_flag: assert property (p_par_flag)
    else $error("parity fault missing at limit");

  property p_rem_block;
    // a read in the same cycle is still acknowledged
    chan_wr && !chan_rd && st_r.setup[7] |=> chan_rej && !chan_ack;
  endproperty
  a_rem_block: assert property (p_rem_block)
    else $error("blocked remote write not rejected");

  property p_reload;
    rom_reload_request && !$past(rom_load_done) |-> !st_r.init_done;
  endproperty
  a_reload: assert property (p_reload)
    else $error("init done during reload");

  property p_init_done;
    rom_load_done |=> st_r.init_done;
  endproperty
  a_init_done: assert property (p_init_done)
    else $error("init done not set");

  property p_cksum;
    st_r.cksum_ok |-> st_r.init_done;
  endproperty
  a_cksum: assert property (p_cksum)
    else $error("checksum ok before init done");

  property p_refok;
    ##2 st_r.ref_sy[1] == $past(ref_clock_detect, 2);
  endproperty
  a_refok: assert property (p_refok)
    else $error("reference status lags wrong");
endmodule : dslc_regs

// ### tb/dslc_i2c_host.sv
// local serial host model driving the clock pin high and low and the open-drain data pin
`timescale 1ns/1ps
module dslc_i2c_host (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // 12 clocks per phase keeps well above the 10 clock minimum
  int ph = 12;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (ph) @(negedge clk_sys);
  endtask : half
  // one byte msb first, ack sampled just before the ninth clock falls
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      half();
      scl = 1'b1;
      half();
      scl = 1'b0;
    end
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    ack = sda_line;
    scl = 1'b0;
    half();
  endtask : put_byte
  // start, address with write, pointer, two data bytes, stop
  task automatic write2(input logic [7:0] r, input logic [7:0] d0,
                        input logic [7:0] d1, output logic ok);
    logic a0, a1, a2, a3;
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
    put_byte(8'h60, a0);
    put_byte(r, a1);
    put_byte(d0, a2);
    put_byte(d1, a3);
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
    ok = ~(a0 | a1 | a2 | a3);
  endtask : write2
  // start, address with write, pointer, repeated start, address with read, one byte, nack, stop
  task automatic read1(input logic [7:0] r, output logic [7:0] d,
                       output logic ok);
    logic a0, a1, a2;
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
    put_byte(8'h60, a0);
    put_byte(r, a1);
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
    put_byte(8'h61, a2);
    // data is sampled at the end of each high phase
    for (int i = 7; i >= 0; i--) begin
      half();
      scl = 1'b1;
      half();
      d[i] = sda_line;
      scl = 1'b0;
    end
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
    ok = ~(a0 | a1 | a2);
  endtask : read1
endmodule : dslc_i2c_host

// ### tb/deser_status_and_link_control_regs_tb.sv
// self-checking bench for the status and link control register bank
`timescale 1ns/1ps
module deser_status_and_link_control_regs_tb;
  logic clk_sys, rstn, scl_in, sda_in, sda_o, sda_oe, host_low, ok;
  logic ref_clock_detect, rom_load_done, rom_cksum_good, rom_reload_request;
  logic chan_wr, chan_rd, chan_ack, chan_rej;
  logic chan_txn_start, chan_txn_done, chan_txn_abort;
  logic [7:0] chan_addr, chan_wdata, chan_rdata, rb;
  logic [3:0] par_err, par_clr, par_fault, fexp;
  logic [7:0] mreg [16];
  int cnt [4];
  int n_mismatch, tests_run;
  // open-drain data line with pull-up
  assign sda_in = ~(sda_oe | host_low);
  dslc_regs #(.TMO_STEP_CYCLES(4)) i_dslc_regs (.clk_sys(clk_sys),
    .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_o(sda_o),
    .sda_oe(sda_oe), .ref_clock_detect(ref_clock_detect),
    .rom_load_done(rom_load_done), .rom_cksum_good(rom_cksum_good),
    .rom_reload_request(rom_reload_request), .chan_wr(chan_wr),
    .chan_rd(chan_rd), .chan_addr(chan_addr), .chan_wdata(chan_wdata),
    .chan_rdata(chan_rdata), .chan_ack(chan_ack), .chan_rej(chan_rej),
    .chan_txn_start(chan_txn_start), .chan_txn_done(chan_txn_done),
    .chan_txn_abort(chan_txn_abort), .par_err(par_err),
    .par_clr(par_clr), .par_fault(par_fault));
  dslc_i2c_host i_dslc_i2c_host (.clk_sys(clk_sys), .sda_line(sda_in),
    .scl(scl_in), .sda_low(host_low));
  // -------------------------------------------------------------------
  // checking and closing
  // -------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // -------------------------------------------------------------------
  // remote register port
  // -------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic blk;
    blk = mreg[8][7];
    @(negedge clk_sys);
    chan_wr = 1'b1;
    chan_addr = a;
    chan_wdata = d;
    @(negedge clk_sys);
    chan_wr = 1'b0;
    check("rej", {15'h0, blk}, {15'h0, chan_rej});
    check("wr_ack", {15'h0, ~blk}, {15'h0, chan_ack});
    check("reload", {15'h0, a == 8'h01 && d[2] && !blk},
          {15'h0, rom_reload_request});
    if (!blk && a >= 8'h05 && a <= 8'h08) begin
      mreg[a[3:0]] = d;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    chan_rd = 1'b1;
    chan_addr = a;
    @(negedge clk_sys);
    chan_rd = 1'b0;
    check("rd_ack", 16'h0001, {15'h0, chan_ack});
    check("rdata", {8'h0, (a <= 8'h08) ? mreg[a[3:0]] : 8'h00},
          {8'h0, chan_rdata});
  endtask : rd
  task automatic load(input logic good);
    @(negedge clk_sys);
    rom_load_done = 1'b1;
    rom_cksum_good = good;
    @(negedge clk_sys);
    rom_load_done = 1'b0;
    mreg[4][6] = 1'b1;
    mreg[4][7] = good;
    rd(8'h04);
  endtask : load
  // -------------------------------------------------------------------
  // parity counting: limit, port, number of error pulses
  // -------------------------------------------------------------------
  task automatic parity(input int lim, input int p, input int k);
    wr(8'h05, 8'(lim >> 8));
    wr(8'h06, 8'(lim));
    // clear all ports: flags are sticky and the limit passes a mixed value
    @(negedge clk_sys);
    par_clr = 4'hF;
    @(negedge clk_sys);
    par_clr = 4'h0;
    cnt = '{0, 0, 0, 0};
    repeat (k) begin
      @(negedge clk_sys);
      par_err[p] = 1'b1;
      @(negedge clk_sys);
      par_err = 4'h0;
      cnt[p]++;
      @(negedge clk_sys);
      for (int q = 0; q < 4; q++) begin
        fexp[q] = cnt[q] >= lim;
      end
      check("fault", {12'h0, fexp}, {12'h0, par_fault});
    end
  endtask : parity
  // -------------------------------------------------------------------
  // watchdog: field, off bit, done at cycle dn, restart at cycle rs
  // -------------------------------------------------------------------
  task automatic wdog(input int f, input logic off, input int dn,
                      input int rs);
    int seen, exp;
    wr(8'h07, {7'(f), off});
    exp = (off || dn > 0) ? 0 : rs + f * 4 + 1;
    seen = 0;
    @(negedge clk_sys);
    chan_txn_start = 1'b1;
    for (int n = 0; n < rs + f * 4 + 12; n++) begin
      @(negedge clk_sys);
      chan_txn_start = (n + 1 == rs);
      chan_txn_done = (n + 1 == dn);
      if (chan_txn_abort === 1'b1 && seen == 0) begin
        seen = n + 1;
      end
    end
    check("abort_at", 16'(exp), 16'(seen));
  endtask : wdog
  // -------------------------------------------------------------------
  // clock, watchdog and main sequence
  // -------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // the longest serial write takes under 2000 cycles, so this is generous
  initial begin
    #3_000_000;
    n_mismatch++;
    results();
  end
  initial begin
    {rstn, ref_clock_detect, rom_load_done, rom_cksum_good} = 4'h0;
    {chan_wr, chan_rd, chan_txn_start, chan_txn_done} = 4'h0;
    {chan_addr, chan_wdata, par_err, par_clr} = 24'h0;
    n_mismatch = 0;
    tests_run = 0;
    cnt = '{0, 0, 0, 0};
    foreach (mreg[i]) mreg[i] = 8'h00;
    mreg[5] = 8'h01;
    mreg[7] = 8'hFE;
    mreg[8] = 8'h1C;
    void'($urandom(32'hc2bf033f));
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    for (int a = 0; a < 10; a++) rd(8'(a));
    $display("test reset values done");
    ref_clock_detect = 1'b1;
    repeat (6) @(negedge clk_sys);
    mreg[4] = 8'h10;
    rd(8'h04);
    load(1'b0);
    wr(8'h01, 8'h04);
    mreg[4] = 8'h10;
    rd(8'h04);
    load(1'b1);
    ref_clock_detect = 1'b0;
    repeat (6) @(negedge clk_sys);
    mreg[4][4] = 1'b0;
    rd(8'h04);
    $display("test status done");
    for (int i = 0; i < 12; i++) begin
      logic [7:0] a, d;
      a = 8'(4 + $urandom_range(0, 5));
      d = 8'($urandom);
      if (a == 8'h07) d[1] = 1'b1;
      if (a == 8'h08) d[7] = 1'b0;
      wr(a, d);
      rd(a);
    end
    $display("test random access done");
    parity(3, $urandom_range(0, 3), 4);
    parity(0, $urandom_range(0, 3), 1);
    parity(256, 2, 3);
    parity(1, 1, 2);
    $display("test parity done");
    wdog(1, 1'b0, 0, 0);
    wdog(3, 1'b0, 0, 0);
    wdog(2, 1'b0, 0, 3);
    wdog(1, 1'b0, 2, 0);
    wdog(1, 1'b1, 0, 0);
    wdog($urandom_range(1, 5), 1'b0, 0, 0);
    $display("test watchdog done");
    // remote writes refused, local port still writes
    wr(8'h08, 8'h9C);
    wr(8'h05, 8'h55);
    rd(8'h05);
    // local port still reads while remote writes are blocked
    i_dslc_i2c_host.read1(8'h08, rb, ok);
    check("i2c_rd_ack", 16'h0001, {15'h0, ok});
    check("i2c_rd", {8'h0, mreg[8]}, {8'h0, rb});
    check("sda_o", 16'h0000, {15'h0, sda_o});
    i_dslc_i2c_host.write2(8'h07, 8'h06, 8'h1C, ok);
    check("i2c_ack", 16'h0001, {15'h0, ok});
    mreg[7] = 8'h06;
    mreg[8] = 8'h1C;
    rd(8'h07);
    rd(8'h08);
    wr(8'h05, 8'hAA);
    rd(8'h05);
    $display("test write block done");
    results();
  end
endmodule : deser_status_and_link_control_regs_tb
